//--- inc/telegram_image_pkg.sv
// Purpose: constants and carriers for the radio telegram process image
// Assumes: one clock, synchronous active-low reset
// Notes: register numbers are the 6-bit numbers carried in the control byte
// Behaviour
// - twelve bytes each way, byte 0 control/status
// - status bit 7 set acknowledges register access
// - status bit 6 zero, bits 5..0 register number
// - telegram data forced zero in register mode
// - control bit 0 toggle fetches next telegram
// - status bit 0 follows control bit 0 when copied
// - process mode: status bit 7 zero, 5..4 zero
// - status bit 6 flags checksum error of telegram
// - status bit 3 flags receive memory full
// - status bit 2 flags telegram waiting
// - status bit 1 flags telegram continuation
// - register 6 reads the status byte
// - register 7 read/write, commands not executed
// - register 8 fixed terminal type code
// - register 9 firmware version, two ASCII characters
// - register 16 hardware version never changes
// - register 29 fixed variant code
// - user writes ignored unless unlock word held
// - unlocked user writes go to RAM and nonvolatile
// - restart clears the unlock word
// - register 32 stored, no effect on behaviour
// - register 35 reads eleven, read-only
package telegram_image_pkg;

	localparam int DATA_BYTES = 11;

	localparam logic [5:0] REG_DIAG     = 6'h06;
	localparam logic [5:0] REG_COMMAND  = 6'h07;
	localparam logic [5:0] REG_TYPE     = 6'h08;
	localparam logic [5:0] REG_FIRMWARE = 6'h09;
	localparam logic [5:0] REG_MUX      = 6'h0A;
	localparam logic [5:0] REG_CHANNELS = 6'h0B;
	localparam logic [5:0] REG_MINLEN   = 6'h0C;
	localparam logic [5:0] REG_DATASTR  = 6'h0D;
	localparam logic [5:0] REG_ALIGN    = 6'h0F;
	localparam logic [5:0] REG_HWVER    = 6'h10;
	localparam logic [5:0] REG_VARIANT  = 6'h1D;
	localparam logic [5:0] REG_UNLOCK   = 6'h1F;
	localparam logic [5:0] REG_FEATURE  = 6'h20;
	localparam logic [5:0] REG_BYTECNT  = 6'h23;

	localparam logic [15:0] RST_COMMAND  = 16'h0000;
	localparam logic [15:0] VAL_MUX      = 16'h0230;
	localparam logic [15:0] VAL_CHANNELS = 16'h0160;
	localparam logic [15:0] VAL_MINLEN   = 16'h6060;
	localparam logic [15:0] VAL_DATASTR  = 16'h0002;
	localparam logic [15:0] RST_ALIGN    = 16'h7F80;
	localparam logic [15:0] RST_UNLOCK   = 16'h0000;
	localparam logic [15:0] VAL_BYTECNT  = 16'h000B;
	localparam logic [15:0] UNLOCK_WORD  = 16'h1235;

	localparam int CB_MODE   = 7;
	localparam int CB_WRITE  = 6;
	localparam int CB_TOGGLE = 0;

	// one entry of the receive memory: the bytes shown in the input image
	typedef struct packed {
		logic [8*DATA_BYTES-1:0] data;
		logic                    chk_err;
		logic                    cont;
	} telegram_chunk_t;

	// write toward nonvolatile storage
	typedef struct packed {
		logic [5:0]  regno;
		logic [15:0] value;
	} nv_write_t;

endpackage : telegram_image_pkg

//--- rtl/telegram_image.sv
// Purpose: process-image interface of a radio telegram terminal
// Assumes: control and output bytes synchronous to clk_i
// Notes: telegram memory is a small FIFO; controller handshakes by toggle
`timescale 1ns/1ns

module telegram_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	// fill side
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	// drain side
	output logic      [WIDTH-1:0] out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	// levels
	output logic                  full_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      count_r;
	logic             push;
	logic             pop;

	assign full_o      = (count_r == (AW+1)'(DEPTH));
	assign in_ready_o  = !full_o;
	assign out_valid_o = (count_r != '0);
	assign out_data_o  = mem_r[rd_ptr_r];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
			end
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule : telegram_fifo

module telegram_image #(
	parameter int          FIFO_DEPTH   = 8,
	parameter logic [15:0] TYPE_CODE    = 16'h0A0B, // arbitrary value
	parameter logic [15:0] FW_VERSION   = 16'h3130, // arbitrary value
	parameter logic [15:0] HW_VERSION   = 16'h0000, // arbitrary value
	parameter logic [15:0] VARIANT_CODE = 16'h0C0D  // arbitrary value
) (
	// clock and reset
	input  wire logic                                clk_i,
	input  wire logic                                rst_n_i,
	// output image from the controller
	input  wire logic [7:0]                          control_byte_i,
	input  wire logic [8*telegram_image_pkg::DATA_BYTES-1:0] out_data_i,
	// input image toward the controller
	output logic      [7:0]                          status_byte_o,
	output logic      [8*telegram_image_pkg::DATA_BYTES-1:0] in_data_o,
	// received telegram chunks from the radio side
	input  wire telegram_image_pkg::telegram_chunk_t chunk_i,
	input  wire logic                                chunk_valid_i,
	output logic                                     chunk_ready_o,
	// nonvolatile storage
	output logic                                     nv_wr_o,
	output telegram_image_pkg::nv_write_t            nv_wr_data_o,
	input  wire logic [15:0]                         nv_feature_i
);
	localparam int DW = 8 * telegram_image_pkg::DATA_BYTES;

	telegram_image_pkg::telegram_chunk_t fifo_out;
	telegram_image_pkg::telegram_chunk_t shown_r;
	logic            fifo_valid;
	logic            fifo_full;
	logic            ack_r;
	logic            reg_mode;
	logic            pop;
	logic [5:0]      regno;
	logic [7:0]      ctrl_last_r;
	logic            access_stb;
	logic            wr_stb;
	logic            user_wr;
	logic [15:0]     wdata;
	logic            unlocked;
	logic [15:0]     unlock_r;
	logic [15:0]     command_r;
	logic [15:0]     align_r;
	logic [15:0]     feature_r;
	logic            loaded_r;
	logic [15:0]     rd_val;
	logic [7:0]      pd_status;

	assign reg_mode = control_byte_i[telegram_image_pkg::CB_MODE];
	assign regno    = control_byte_i[5:0];
	assign wdata    = out_data_i[DW-1 -: 16];

	telegram_fifo #(
		.WIDTH ($bits(telegram_image_pkg::telegram_chunk_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n_i),
		.in_data_i   (chunk_i),
		.in_valid_i  (chunk_valid_i),
		.in_ready_o  (chunk_ready_o),
		.out_data_o  (fifo_out),
		.out_valid_o (fifo_valid),
		.out_ready_i (pop),
		.full_o      (fifo_full)
	);

	// a toggle with an empty memory waits until a telegram arrives
	assign pop = !reg_mode && (control_byte_i[telegram_image_pkg::CB_TOGGLE] != ack_r) && fifo_valid;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			shown_r <= '0;
			ack_r   <= 1'b0;
		end else if (pop) begin
			shown_r <= fifo_out;
			ack_r   <= control_byte_i[telegram_image_pkg::CB_TOGGLE];
		end
	end

	// register accesses fire once per change of the control byte
	assign access_stb = reg_mode && (control_byte_i != ctrl_last_r);
	assign wr_stb     = access_stb && control_byte_i[telegram_image_pkg::CB_WRITE];
	assign unlocked   = (unlock_r == telegram_image_pkg::UNLOCK_WORD);
	assign user_wr    = wr_stb && unlocked && ((regno == telegram_image_pkg::REG_COMMAND) ||
		(regno == telegram_image_pkg::REG_ALIGN) || (regno == telegram_image_pkg::REG_FEATURE));

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ctrl_last_r <= 8'h00;
		end else begin
			ctrl_last_r <= control_byte_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			unlock_r <= telegram_image_pkg::RST_UNLOCK;
		end else if (wr_stb && regno == telegram_image_pkg::REG_UNLOCK) begin
			unlock_r <= wdata;
		end
	end

	// commands are stored only, nothing acts on them
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			command_r <= telegram_image_pkg::RST_COMMAND;
			align_r   <= telegram_image_pkg::RST_ALIGN;
		end else if (user_wr) begin
			if (regno == telegram_image_pkg::REG_COMMAND) begin
				command_r <= wdata;
			end else if (regno == telegram_image_pkg::REG_ALIGN) begin
				align_r <= wdata;
			end
		end
	end

	// feature word is retained in storage: reloaded the cycle after reset release
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			feature_r <= 16'h0000;
			loaded_r  <= 1'b0;
		end else if (!loaded_r) begin
			feature_r <= nv_feature_i;
			loaded_r  <= 1'b1;
		end else if (user_wr && regno == telegram_image_pkg::REG_FEATURE) begin
			feature_r <= wdata;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			nv_wr_o      <= 1'b0;
			nv_wr_data_o <= '0;
		end else begin
			nv_wr_o <= user_wr;
			if (user_wr) begin
				nv_wr_data_o <= '{regno: regno, value: wdata};
			end
		end
	end

	assign pd_status = {1'b0, shown_r.chk_err, 2'b00, fifo_full, fifo_valid, shown_r.cont, ack_r};

	always_comb begin
		rd_val = 16'h0000;
		if (regno == telegram_image_pkg::REG_DIAG) begin
			rd_val = {8'h00, pd_status};
		end else if (regno == telegram_image_pkg::REG_COMMAND) begin
			rd_val = command_r;
		end else if (regno == telegram_image_pkg::REG_TYPE) begin
			rd_val = TYPE_CODE;
		end else if (regno == telegram_image_pkg::REG_FIRMWARE) begin
			rd_val = FW_VERSION;
		end else if (regno == telegram_image_pkg::REG_MUX) begin
			rd_val = telegram_image_pkg::VAL_MUX;
		end else if (regno == telegram_image_pkg::REG_CHANNELS) begin
			rd_val = telegram_image_pkg::VAL_CHANNELS;
		end else if (regno == telegram_image_pkg::REG_MINLEN) begin
			rd_val = telegram_image_pkg::VAL_MINLEN;
		end else if (regno == telegram_image_pkg::REG_DATASTR) begin
			rd_val = telegram_image_pkg::VAL_DATASTR;
		end else if (regno == telegram_image_pkg::REG_ALIGN) begin
			rd_val = align_r;
		end else if (regno == telegram_image_pkg::REG_HWVER) begin
			rd_val = HW_VERSION;
		end else if (regno == telegram_image_pkg::REG_VARIANT) begin
			rd_val = VARIANT_CODE;
		end else if (regno == telegram_image_pkg::REG_UNLOCK) begin
			rd_val = unlock_r;
		end else if (regno == telegram_image_pkg::REG_FEATURE) begin
			rd_val = feature_r;
		end else if (regno == telegram_image_pkg::REG_BYTECNT) begin
			rd_val = telegram_image_pkg::VAL_BYTECNT;
		end
	end

	// input image: byte 0 status, bytes 1..11 data
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			status_byte_o <= 8'h00;
			in_data_o     <= '0;
		end else if (reg_mode) begin
			status_byte_o <= {1'b1, 1'b0, regno};
			// telegram bytes are hidden; only a read answer shows, high byte first
			in_data_o <= control_byte_i[telegram_image_pkg::CB_WRITE] ? '0 : {rd_val, (DW-16)'(0)};
		end else begin
			status_byte_o <= pd_status;
			in_data_o     <= shown_r.data;
		end
	end

	property p_reg_ack;
		@(posedge clk_i) disable iff (!rst_n_i) reg_mode |=> status_byte_o[7];
	endproperty
	a_reg_ack: assert property (p_reg_ack) else $error("register ack missing");

	property p_reg_num;
		@(posedge clk_i) disable iff (!rst_n_i)
			reg_mode |=> status_byte_o[5:0] == $past(control_byte_i[5:0]) && !status_byte_o[6];
	endproperty
	a_reg_num: assert property (p_reg_num) else $error("register number not echoed");

	property p_pd_zero;
		@(posedge clk_i) disable iff (!rst_n_i) reg_mode |=> in_data_o[DW-17:0] == '0;
	endproperty
	a_pd_zero: assert property (p_pd_zero) else $error("data not zero in register mode");

	property p_ack_copy;
		@(posedge clk_i) disable iff (!rst_n_i)
			(pop ##1 !reg_mode) |=> status_byte_o[0] == $past(control_byte_i[0], 2)
				&& in_data_o == $past(fifo_out.data, 2);
	endproperty
	a_ack_copy: assert property (p_ack_copy) else $error("telegram ack wrong");

	property p_pd_mode;
		@(posedge clk_i) disable iff (!rst_n_i) !reg_mode |=> !status_byte_o[7] && status_byte_o[5:4] == 2'b00;
	endproperty
	a_pd_mode: assert property (p_pd_mode) else $error("process mode status bits wrong");

	property p_err;
		@(posedge clk_i) disable iff (!rst_n_i)
			!reg_mode |=> status_byte_o[6] == $past(shown_r.chk_err) && status_byte_o[1] == $past(shown_r.cont);
	endproperty
	a_err: assert property (p_err) else $error("error or continuation flag wrong");

	property p_full;
		@(posedge clk_i) disable iff (!rst_n_i) (!reg_mode && fifo_full) |=> status_byte_o[3] && status_byte_o[2];
	endproperty
	a_full: assert property (p_full) else $error("full flag missing");

	property p_wait;
		@(posedge clk_i) disable iff (!rst_n_i) !reg_mode |=> status_byte_o[2] == $past(fifo_valid);
	endproperty
	a_wait: assert property (p_wait) else $error("waiting flag wrong");

	property p_lock;
		@(posedge clk_i) disable iff (!rst_n_i)
			(loaded_r && wr_stb && !unlocked && regno == telegram_image_pkg::REG_FEATURE)
				|=> feature_r == $past(feature_r) && !nv_wr_o;
	endproperty
	a_lock: assert property (p_lock) else $error("locked write accepted");

	property p_count;
		@(posedge clk_i) disable iff (!rst_n_i)
			(reg_mode && !control_byte_i[6] && regno == telegram_image_pkg::REG_BYTECNT)
				|=> in_data_o[DW-1 -: 16] == telegram_image_pkg::VAL_BYTECNT;
	endproperty
	a_count: assert property (p_count) else $error("byte count read wrong");

	// a request against an empty memory must not move the acknowledge
	property p_ack_hold;
		@(posedge clk_i) disable iff (!rst_n_i)
			(!reg_mode && !pop) ##1 !reg_mode |=> $stable(status_byte_o[0]);
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("acknowledge moved without a copy");

	property p_cont;
		@(posedge clk_i) disable iff (!rst_n_i)
			(pop ##1 !reg_mode) |=> status_byte_o[1] == $past(fifo_out.cont, 2);
	endproperty
	a_cont: assert property (p_cont) else $error("continuation flag wrong");

	property p_hw_fixed;
		@(posedge clk_i) disable iff (!rst_n_i)
			(reg_mode && !control_byte_i[6] && regno == telegram_image_pkg::REG_HWVER)
				|=> in_data_o[DW-1 -: 16] == HW_VERSION;
	endproperty
	a_hw_fixed: assert property (p_hw_fixed) else $error("hardware version changed");

	// storage sees every accepted user write exactly once, one cycle later
	property p_nv_pulse;
		@(posedge clk_i) disable iff (!rst_n_i)
			user_wr |=> nv_wr_o && nv_wr_data_o.regno == $past(regno) && nv_wr_data_o.value == $past(wdata);
	endproperty
	a_nv_pulse: assert property (p_nv_pulse) else $error("storage write missing");

endmodule : telegram_image

//--- verif/telegram_source.sv
// Purpose: radio-side model offering numbered telegram chunks
// Assumes: chunk k carries k in its lowest data byte
// Notes: payload is scrambled while nothing is offered
`timescale 1ns/1ns

module telegram_source (
	// clock and reset
	input  wire logic                           clk_i,
	input  wire logic                           rst_n_i,
	// offer control from the bench
	input  wire logic                           send_i,
	// chunk stream
	output telegram_image_pkg::telegram_chunk_t chunk_o,
	output logic                                valid_o,
	input  wire logic                           ready_i
);
	logic [7:0] idx_r;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i)
			idx_r <= 8'h00;
		else if (send_i && ready_i)
			idx_r <= idx_r + 8'h01;
	end

	assign valid_o = send_i;

	// inverted payload so a stale value never looks valid
	always_comb begin
		chunk_o.data    = {80'h0, idx_r};
		chunk_o.chk_err = idx_r[0];
		chunk_o.cont    = idx_r[1];
		if (!send_i)
			chunk_o = ~chunk_o;
	end
endmodule : telegram_source

//--- verif/telegram_image_bench.sv
// Purpose: self-checking bench for the telegram process image
// Assumes: inputs change 1 ns after the rising edge
// Notes: id parameters get arbitrary values of our own
`timescale 1ns/1ns

module telegram_image_bench;
	logic                                clk_i   = 1'b0;
	logic                                rst_n_i = 1'b0;
	logic [7:0]                          ctrl    = 8'h00;
	logic [87:0]                         od      = 88'h0;
	logic [7:0]                          stat;
	logic [87:0]                         idata;
	telegram_image_pkg::telegram_chunk_t chunk;
	telegram_image_pkg::nv_write_t       nv_data;
	logic                                cvalid;
	logic                                cready;
	logic                                nv_wr;
	logic                                send    = 1'b0;
	logic                                tg      = 1'b0;
	logic [15:0]                         nv_feat = 16'h0002;
	int                                  error_cnt, comparisons, nv_cnt, n;
	logic [5:0]  rn[15] = '{6'h06, 6'h07, 6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D,
		6'h0F, 6'h10, 6'h1D, 6'h1F, 6'h20, 6'h23, 6'h05};
	logic [15:0] rv[15] = '{16'h0000, 16'h0000, 16'h2468, 16'h3242, 16'h0230, 16'h0160,
		16'h6060, 16'h0002, 16'h7F80, 16'h0003, 16'h00C5, 16'h0000, 16'h0002, 16'h000B, 16'h0000};

	always #10 clk_i = ~clk_i;
	always @(posedge clk_i) if (nv_wr === 1'b1) nv_cnt++;
	// nonvolatile storage model: keeps the feature word across a restart
	always @(posedge clk_i) if (nv_wr === 1'b1 && nv_data.regno == 6'h20) nv_feat <= nv_data.value;

	// identity values below are arbitrary
	telegram_image #(.TYPE_CODE(16'h2468), .FW_VERSION(16'h3242), .HW_VERSION(16'h0003),
		.VARIANT_CODE(16'h00C5)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .control_byte_i(ctrl),
		.out_data_i(od), .status_byte_o(stat), .in_data_o(idata), .chunk_i(chunk),
		.chunk_valid_i(cvalid), .chunk_ready_o(cready), .nv_wr_o(nv_wr),
		.nv_wr_data_o(nv_data), .nv_feature_i(nv_feat));

	telegram_source src (.clk_i(clk_i), .rst_n_i(rst_n_i), .send_i(send), .chunk_o(chunk),
		.valid_o(cvalid), .ready_i(cready));

	task automatic chk(input logic [87:0] got, input logic [87:0] exp, input string msg = "value");
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic cyc(input int c);
		repeat (c) @(posedge clk_i);
		#1;
	endtask : cyc

	// the control byte changes on every call, so each write executes once
	task automatic acc(input logic w, input logic [5:0] r, input logic [15:0] v);
		ctrl = {1'b1, w, r};
		od   = {v, 72'h0};
		cyc(2);
		chk(stat, {2'b10, r}, "register status");
	endtask : acc

	task automatic rd(input logic [5:0] r, input logic [15:0] e);
		acc(1'b0, r, 16'h0000);
		chk(idata, {e, 72'h0}, "register read");
	endtask : rd

	task automatic wr(input logic [5:0] r, input logic [15:0] v);
		acc(1'b1, r, v);
		chk(idata, 88'h0, "write data");
	endtask : wr

	task automatic awt(input logic [7:0] j);
		n = 0;
		while (stat[0] !== tg && n < 20) begin
			cyc(1);
			n++;
		end
		chk(stat[0], tg, "ack");
		chk(idata, {80'h0, j}, "telegram data");
		chk({stat[7:4], stat[1]}, {1'b0, j[0], 2'b00, j[1]}, "flags");
	endtask : awt

	task automatic stop_test;
		$display("counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test

	initial begin
		#200000;
		error_cnt++;
		stop_test();
	end

	initial begin
		cyc(5);
		rst_n_i = 1'b1;
		cyc(2);
		chk(stat, 8'h00, "reset status");
		chk(idata, 88'h0, "reset data");
		chk(cready, 1'b1, "reset ready");
		for (int i = 0; i < 15; i++)
			rd(rn[i], rv[i]);
		$display("test register table done");
		wr(6'h07, 16'hAAAA);
		rd(6'h07, 16'h0000);
		chk(nv_cnt, 0);
		wr(6'h08, 16'hFFFF);
		rd(6'h08, 16'h2468);
		wr(6'h23, 16'h0001);
		rd(6'h23, 16'h000B);
		wr(6'h1F, 16'h1235);
		rd(6'h1F, 16'h1235);
		wr(6'h07, 16'h5A5A);
		chk(nv_cnt, 1);
		chk(nv_data, {6'h07, 16'h5A5A});
		rd(6'h07, 16'h5A5A);
		wr(6'h20, 16'h0007);
		rd(6'h20, 16'h0007);
		wr(6'h10, 16'h0001);
		rd(6'h10, 16'h0003);
		wr(6'h1F, 16'h0000);
		wr(6'h07, 16'h1111);
		rd(6'h07, 16'h5A5A);
		wr(6'h1F, 16'h1235);
		// leave register mode so the held write is not taken again after restart
		ctrl    = 8'h00;
		rst_n_i = 1'b0;
		cyc(5);
		rst_n_i = 1'b1;
		cyc(2);
		chk(stat, 8'h00, "restart status");
		rd(6'h1F, 16'h0000);
		wr(6'h20, 16'h00FF);
		rd(6'h20, 16'h0007);
		chk(nv_cnt, 2, "stored writes");
		$display("test write protection done");
		ctrl = 8'h00;
		send = 1'b1;
		n = 0;
		while (cready !== 1'b0 && n < 20) begin
			cyc(1);
			n++;
		end
		send = 1'b0;
		cyc(2);
		chk(stat[3:2], 2'b11);
		for (int j = 0; j < 8; j++) begin
			tg   = ~tg;
			ctrl = {7'h00, tg};
			awt(8'(j));
		end
		cyc(2);
		chk(stat[3:2], 2'b00);
		// an empty memory must hold the request
		tg   = ~tg;
		ctrl = {7'h00, tg};
		cyc(4);
		chk(stat[0], !tg);
		send = 1'b1;
		cyc(1);
		send = 1'b0;
		awt(8'h08);
		rd(6'h06, {15'h0000, tg});
		$display("test telegram handshake done");
		stop_test();
	end
endmodule : telegram_image_bench
